/* File: design/wdt_consts.svh */
// constants for the watchdog interval timer: byte addresses, field positions, reset values, counts
// assumes a 32-bit byte address and 32-bit data on the register port
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_ADDR_W 32
`define WDT_DATA_W 32
`define WDT_REG_W 16
`define WDT_PRE_W 8
`define WDT_DIV_W 7
`define WDT_RST_W 8

`define WDT_CTRL_ADDR 32'h5300_0000
`define WDT_RELOAD_ADDR 32'h5300_0004
`define WDT_COUNT_ADDR 32'h5300_0008
`define WDT_STAT_ADDR 32'h5300_000C
`define WDT_MASK_ADDR 32'h5300_0010

`define WDT_CTRL_PRE_HI 15
`define WDT_CTRL_PRE_LO 8
`define WDT_CTRL_EN_BIT 5
`define WDT_CTRL_DIV_HI 4
`define WDT_CTRL_DIV_LO 3
`define WDT_CTRL_IRQ_BIT 2
`define WDT_CTRL_RST_BIT 0
`define WDT_CTRL_WMASK 16'hFF3D

`define WDT_CTRL_RESET 16'h8021
`define WDT_RELOAD_RESET 16'h8000
`define WDT_COUNT_RESET 16'h8000
`define WDT_MASK_RESET 16'h0003

`define WDT_STAT_TIMEOUT_BIT 0
`define WDT_STAT_RESET_BIT 1
`define WDT_STAT_USED 16'h0003

`define WDT_DIV16_LAST 7'h0F
`define WDT_DIV32_LAST 7'h1F
`define WDT_DIV64_LAST 7'h3F
`define WDT_DIV128_LAST 7'h7F

`define WDT_RST_CYCLES 8'h80

`endif

/* File: design/wdt_link_if.sv */
// link between the watchdog core and its tick generator and reset stretcher
// assumes all parties run on the same sys_clk
`timescale 1ns/10ps
`include "wdt_consts.svh"
interface wdt_link_if;
	import wdt_pkg::*;
	wdt_pre_t prescale;
	wdt_div_t div_sel;
	logic run;
	logic tick;
	logic fire;
	logic rst_active;
	modport tick_mp (input prescale, input div_sel, input run, output tick);
	modport pulse_mp (input fire, output rst_active);
	modport core_mp (output prescale, output div_sel, output run, output fire, input tick, input rst_active);
endinterface

/* File: design/wdt_pkg.sv */
// types shared by the watchdog interval timer modules
// assumes wdt_consts.svh for widths
`include "wdt_consts.svh"
package wdt_pkg;
	typedef logic [`WDT_ADDR_W-1:0] wdt_addr_t;
	typedef logic [`WDT_DATA_W-1:0] wdt_data_t;
	typedef logic [`WDT_REG_W-1:0] wdt_word_t;
	typedef logic [`WDT_PRE_W-1:0] wdt_pre_t;
	typedef enum logic [1:0] {wdt_div_16, wdt_div_32, wdt_div_64, wdt_div_128} wdt_div_t;
endpackage

/* File: design/wdt_rst_stretch.sv */
// stretches a one-cycle time-out into the fixed-length internal reset pulse
// assumes fire is a one-cycle pulse on sys_clk
`timescale 1ns/10ps
`include "wdt_consts.svh"
module wdt_rst_stretch (
	input wire logic sys_clk,
	input wire logic nrst,
	wdt_link_if.pulse_mp lnk
);
	import wdt_pkg::*;

	logic [`WDT_RST_W-1:0] cnt_reg, cnt_next;
	logic [`WDT_RST_W:0] run_reg, run_next;

	// no retrigger while active, so the pulse length is always exact
	always_comb
	begin
		cnt_next = cnt_reg;
		if (cnt_reg != '0)
			cnt_next = cnt_reg - 8'h01;
		else if (lnk.fire)
			cnt_next = `WDT_RST_CYCLES;
	end

	always_comb
	begin
		run_next = '0;
		if (cnt_reg != '0)
			run_next = run_reg + 9'h001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			cnt_reg <= '0;
			run_reg <= '0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
		end
	end

	assign lnk.rst_active = (cnt_reg != '0);

	pulse_length_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(lnk.rst_active) |-> run_reg == {1'b0, `WDT_RST_CYCLES})
		else $error("reset pulse length wrong");
endmodule

/* File: design/wdt_tick_gen.sv */
// prescaler and second divider producing the one-cycle counter tick
// assumes prescale and div_sel come from registers on sys_clk
`timescale 1ns/10ps
`include "wdt_consts.svh"
module wdt_tick_gen #(
	parameter int PRE_W = `WDT_PRE_W
) (
	input wire logic sys_clk,
	input wire logic nrst,
	wdt_link_if.tick_mp lnk
);
	import wdt_pkg::*;

	if (PRE_W != `WDT_PRE_W)
	begin : g_chk
		$error("prescaler width must match the control field");
	end

	logic [PRE_W-1:0] pre_reg, pre_next;
	logic [`WDT_DIV_W-1:0] div_reg, div_next, div_last;
	logic tick_reg, tick_next;

	always_comb
	begin
		case (lnk.div_sel)
			wdt_div_16: div_last = `WDT_DIV16_LAST;
			wdt_div_32: div_last = `WDT_DIV32_LAST;
			wdt_div_64: div_last = `WDT_DIV64_LAST;
			default: div_last = `WDT_DIV128_LAST;
		endcase
	end

	// a divider shortened on the fly above its new limit wraps at the next prescaler wrap rather than running to 127
	always_comb
	begin
		pre_next = pre_reg;
		div_next = div_reg;
		tick_next = 1'b0;
		if (!lnk.run)
		begin
			pre_next = '0;
			div_next = '0;
		end
		else if (pre_reg >= lnk.prescale)
		begin
			pre_next = '0;
			if (div_reg >= div_last)
			begin
				div_next = '0;
				tick_next = 1'b1;
			end
			else
				div_next = div_reg + 7'h01;
		end
		else
			pre_next = pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			pre_reg <= '0;
			div_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			pre_reg <= pre_next;
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	// the registered tick lags a stop by one cycle, so gate it or a disable would still step the counter
	assign lnk.tick = tick_reg && lnk.run;

	tick_gap_a: assert property (@(posedge sys_clk) disable iff (!nrst) tick_reg |=> !tick_reg [*8])
		else $error("ticks closer than the smallest divider allows");
	tick_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		tick_reg |-> $past(lnk.run) && $past(div_reg) >= $past(div_last))
		else $error("tick without a full divider cycle");
endmodule

/* File: design/wdt_top.sv */
// watchdog and interval timer: registers, down-counter, interrupt status, reset output
// assumes a single sys_clk, a one-cycle strobe register port, debug acknowledge from another domain
`timescale 1ns/10ps
`include "wdt_consts.svh"
module wdt_top (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire wdt_pkg::wdt_addr_t bus_addr,
	input wire wdt_pkg::wdt_data_t bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output wdt_pkg::wdt_data_t bus_rdata,
	input wire logic core_debug_acknowledge,
	output logic wdog_reset_out,
	output logic wdog_irq
);
	import wdt_pkg::*;

	wdt_link_if lnk ();

	wdt_word_t ctrl_reg, ctrl_next;
	wdt_word_t reload_reg, reload_next;
	wdt_word_t count_reg, count_next;
	wdt_word_t stat_reg, stat_next;
	wdt_word_t mask_reg, mask_next;
	wdt_data_t rdata_reg, rdata_next;
	logic dbg_meta_reg, dbg_sync_reg;
	logic timeout;
	logic ctrl_wr, reload_wr, count_wr, mask_wr, stat_rd;
	logic ctrl_en, ctrl_irq_en, ctrl_rst_en;
	wdt_word_t stat_set;

	wdt_tick_gen #(
		.PRE_W(`WDT_PRE_W)
	) i_wdt_tick_gen (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.lnk(lnk.tick_mp)
	);

	wdt_rst_stretch i_wdt_rst_stretch (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.lnk(lnk.pulse_mp)
	);

	// debug acknowledge belongs to the core's domain; two stages before use
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			dbg_meta_reg <= 1'b0;
			dbg_sync_reg <= 1'b0;
		end
		else
		begin
			dbg_meta_reg <= core_debug_acknowledge;
			dbg_sync_reg <= dbg_meta_reg;
		end
	end

	always_comb
	begin
		ctrl_wr = 1'b0;
		reload_wr = 1'b0;
		count_wr = 1'b0;
		mask_wr = 1'b0;
		stat_rd = 1'b0;
		if (bus_addr == `WDT_CTRL_ADDR)
			ctrl_wr = bus_wr;
		else if (bus_addr == `WDT_RELOAD_ADDR)
			reload_wr = bus_wr;
		else if (bus_addr == `WDT_COUNT_ADDR)
			count_wr = bus_wr;
		else if (bus_addr == `WDT_MASK_ADDR)
			mask_wr = bus_wr;
		else if (bus_addr == `WDT_STAT_ADDR)
			stat_rd = bus_rd;
	end

	assign ctrl_en = ctrl_reg[`WDT_CTRL_EN_BIT];
	assign ctrl_irq_en = ctrl_reg[`WDT_CTRL_IRQ_BIT];
	assign ctrl_rst_en = ctrl_reg[`WDT_CTRL_RST_BIT];

	// reserved control bits are not stored and read as zero
	always_comb
	begin
		ctrl_next = ctrl_reg;
		reload_next = reload_reg;
		mask_next = mask_reg;
		if (ctrl_wr)
			ctrl_next = bus_wdata[`WDT_REG_W-1:0] & `WDT_CTRL_WMASK;
		if (reload_wr)
			reload_next = bus_wdata[`WDT_REG_W-1:0];
		if (mask_wr)
			mask_next = bus_wdata[`WDT_REG_W-1:0] & `WDT_STAT_USED;
	end

	// a software load beats a tick landing in the same cycle; that tick's time-out is dropped
	always_comb
	begin
		count_next = count_reg;
		timeout = 1'b0;
		if (count_wr)
			count_next = bus_wdata[`WDT_REG_W-1:0];
		else if (lnk.tick)
		begin
			if (count_reg <= 16'h0001)
			begin
				timeout = 1'b1;
				count_next = reload_reg;
			end
			else
				count_next = count_reg - 16'h0001;
		end
	end

	assign lnk.prescale = ctrl_reg[`WDT_CTRL_PRE_HI:`WDT_CTRL_PRE_LO];
	assign lnk.div_sel = wdt_div_t'(ctrl_reg[`WDT_CTRL_DIV_HI:`WDT_CTRL_DIV_LO]);
	assign lnk.run = ctrl_en;
	assign lnk.fire = timeout && ctrl_rst_en && !dbg_sync_reg;

	always_comb
	begin
		stat_set = '0;
		stat_set[`WDT_STAT_TIMEOUT_BIT] = timeout && ctrl_irq_en;
		stat_set[`WDT_STAT_RESET_BIT] = lnk.fire;
		stat_next = stat_reg;
		if (stat_rd)
			stat_next = '0;
		stat_next = stat_next | stat_set;
	end

	always_comb
	begin
		rdata_next = '0;
		if (bus_rd)
		begin
			if (bus_addr == `WDT_CTRL_ADDR)
				rdata_next = {16'h0000, ctrl_reg};
			else if (bus_addr == `WDT_RELOAD_ADDR)
				rdata_next = {16'h0000, reload_reg};
			else if (bus_addr == `WDT_COUNT_ADDR)
				rdata_next = {16'h0000, count_reg};
			else if (bus_addr == `WDT_STAT_ADDR)
				rdata_next = {16'h0000, stat_reg};
			else if (bus_addr == `WDT_MASK_ADDR)
				rdata_next = {16'h0000, mask_reg};
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ctrl_reg <= `WDT_CTRL_RESET;
			reload_reg <= `WDT_RELOAD_RESET;
			count_reg <= `WDT_COUNT_RESET;
			stat_reg <= '0;
			mask_reg <= `WDT_MASK_RESET;
			rdata_reg <= '0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			reload_reg <= reload_next;
			count_reg <= count_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			rdata_reg <= rdata_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign wdog_reset_out = lnk.rst_active;
	assign wdog_irq = |(stat_reg & mask_reg);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence count_read_s;
		bus_rd && bus_addr == `WDT_COUNT_ADDR;
	endsequence

	sequence ctrl_write_s;
		bus_wr && bus_addr == `WDT_CTRL_ADDR;
	endsequence

	sequence reload_write_s;
		bus_wr && bus_addr == `WDT_RELOAD_ADDR;
	endsequence

	sequence count_write_s;
		bus_wr && bus_addr == `WDT_COUNT_ADDR;
	endsequence

	sequence mask_write_s;
		bus_wr && bus_addr == `WDT_MASK_ADDR;
	endsequence

	sequence ctrl_read_s;
		bus_rd && bus_addr == `WDT_CTRL_ADDR;
	endsequence

	sequence reload_read_s;
		bus_rd && bus_addr == `WDT_RELOAD_ADDR;
	endsequence

	sequence stat_read_s;
		bus_rd && bus_addr == `WDT_STAT_ADDR;
	endsequence

	sequence pulse_start_s;
		$rose(wdog_reset_out);
	endsequence

	sequence pulse_body_s;
		wdog_reset_out [*8];
	endsequence

	prescale_store_a: assert property (ctrl_write_s |=> ctrl_reg[15:8] == $past(bus_wdata[15:8]))
		else $error("prescaler field not stored");
	reserved_zero_a: assert property (ctrl_reg[7:6] == 2'b00 && !ctrl_reg[1])
		else $error("reserved control bits not zero");
	disable_hold_a: assert property (!ctrl_en && !count_wr |=> count_reg == $past(count_reg))
		else $error("counter moved while disabled");
	enable_noload_a: assert property ($rose(ctrl_en) && !$past(count_wr) |-> count_reg == $past(count_reg))
		else $error("enable loaded the counter");
	reload_on_out_a: assert property (timeout && !count_wr |=> count_reg == $past(reload_reg))
		else $error("counter not reloaded at time-out");
	count_step_a: assert property (lnk.tick && !timeout && !count_wr |=> count_reg == $past(count_reg) - 16'h0001)
		else $error("counter did not step down by one");
	count_read_a: assert property (count_read_s |=> bus_rdata == {16'h0000, $past(count_reg)})
		else $error("count readback wrong");
	reset_cause_a: assert property ($rose(wdog_reset_out) |-> $past(timeout && ctrl_rst_en && !dbg_sync_reg))
		else $error("reset output without an allowed time-out");
	reset_follow_a: assert property (timeout && ctrl_rst_en && !dbg_sync_reg && !wdog_reset_out |=> wdog_reset_out [*8])
		else $error("time-out did not raise reset");
	irq_set_a: assert property ($rose(stat_reg[0]) |-> $past(timeout && ctrl_irq_en))
		else $error("interrupt status set without permitted time-out");
	irq_out_a: assert property (timeout && ctrl_irq_en && mask_reg[0] && !mask_wr |=> wdog_irq)
		else $error("interrupt output missed a time-out");
	read_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == '0)
		else $error("read data outside the answer cycle");
	enable_store_a: assert property (ctrl_write_s |=> ctrl_en == $past(bus_wdata[`WDT_CTRL_EN_BIT]))
		else $error("enable bit not stored");
	div_store_a: assert property (ctrl_write_s |=> ctrl_reg[4:3] == $past(bus_wdata[4:3]))
		else $error("divider select not stored");
	irq_en_store_a: assert property (ctrl_write_s |=> ctrl_irq_en == $past(bus_wdata[`WDT_CTRL_IRQ_BIT]))
		else $error("interrupt permit bit not stored");
	rst_en_store_a: assert property (ctrl_write_s |=> ctrl_rst_en == $past(bus_wdata[`WDT_CTRL_RST_BIT]))
		else $error("reset permit bit not stored");
	ctrl_hold_a: assert property (!ctrl_wr |=> ctrl_reg == $past(ctrl_reg))
		else $error("control changed without a write");
	reload_store_a: assert property (reload_write_s |=> reload_reg == $past(bus_wdata[15:0]))
		else $error("reload value not stored");
	reload_hold_a: assert property (!reload_wr |=> reload_reg == $past(reload_reg))
		else $error("reload value changed without a write");
	count_load_a: assert property (count_write_s |=> count_reg == $past(bus_wdata[15:0]))
		else $error("count write not loaded");
	count_stand_a: assert property (!lnk.tick && !count_wr |=> count_reg == $past(count_reg))
		else $error("counter moved between ticks");
	mask_store_a: assert property (mask_write_s |=> mask_reg == ($past(bus_wdata[15:0]) & 16'h0003))
		else $error("mask not stored");
	ctrl_read_a: assert property (ctrl_read_s |=> bus_rdata == {16'h0000, $past(ctrl_reg)})
		else $error("control readback wrong");
	reload_read_a: assert property (reload_read_s |=> bus_rdata == {16'h0000, $past(reload_reg)})
		else $error("reload readback wrong");
	stat_read_a: assert property (stat_read_s |=> bus_rdata == {16'h0000, $past(stat_reg)})
		else $error("status readback wrong");
	stat_clear_a: assert property (stat_rd && !timeout |=> stat_reg == 16'h0000)
		else $error("status not cleared by its read");
	stat_sticky_a: assert property (!stat_rd |=> (stat_reg & $past(stat_reg)) == $past(stat_reg))
		else $error("status bit dropped without a read");
	irq_status_a: assert property (timeout && ctrl_irq_en |=> stat_reg[0])
		else $error("permitted time-out did not set status");
	rst_inhibit_a: assert property (timeout && !ctrl_rst_en && !wdog_reset_out |=> !wdog_reset_out)
		else $error("reset raised while inhibited");
	dbg_block_a: assert property (dbg_sync_reg && !wdog_reset_out |=> !wdog_reset_out)
		else $error("reset raised under debug acknowledge");
	pulse_hold_a: assert property (pulse_start_s |-> pulse_body_s)
		else $error("reset pulse ended early");
	unmapped_read_a: assert property (bus_rd && bus_addr > `WDT_MASK_ADDR |=> bus_rdata == '0)
		else $error("unmapped read returned data");
endmodule

/* File: verif/wdt_top_tb.sv */
// self-checking bench for the watchdog interval timer top
// assumes wdt_top alone on one 40 MHz clock; the bench plays the register master and the debug source
`timescale 1ns/10ps
`include "wdt_consts.svh"
module wdt_top_tb;
	import wdt_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	wdt_addr_t bus_addr = '0;
	wdt_data_t bus_wdata = '0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	wdt_data_t bus_rdata;
	logic core_debug_acknowledge = 1'b0;
	logic wdog_reset_out;
	logic wdog_irq;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;

	always #12.5 sys_clk = ~sys_clk;

	wdt_top i_wdt_top (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata),
		.core_debug_acknowledge(core_debug_acknowledge),
		.wdog_reset_out(wdog_reset_out),
		.wdog_irq(wdog_irq)
	);

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ceiling well above the longest divider sweep, so a stuck handshake ends the run
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input wdt_addr_t a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= {16'h0000, d};
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rdchk(input string what, input wdt_addr_t a, input logic [31:0] exp);
		@(posedge sys_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		chk(what, bus_rdata, exp);
	endtask

	function automatic logic [15:0] ctl(input logic [7:0] p, input logic [1:0] d, input logic en,
		input logic irq, input logic rst);
		return {p, 2'b00, en, d, irq, 1'b0, rst};
	endfunction

	function automatic int per(input logic [7:0] p, input logic [1:0] d);
		return (int'(p) + 1) * (16 << d);
	endfunction

	// stop first so the prescaler and divider restart from zero and no tick steps the count before the new control is written
	task automatic arm(input logic [15:0] c, input logic [15:0] n);
		wr(`WDT_CTRL_ADDR, c & 16'hFFDF);
		wr(`WDT_COUNT_ADDR, n);
		wr(`WDT_CTRL_ADDR, c);
	endtask

	initial
	begin
		logic [7:0] p;
		logic [15:0] n;
		logic [15:0] r;
		int t;
		int w;
		void'($urandom(34));
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		rdchk("ctrl", `WDT_CTRL_ADDR, 32'h0000_8021);
		rdchk("reload", `WDT_RELOAD_ADDR, 32'h0000_8000);
		rdchk("count", `WDT_COUNT_ADDR, 32'h0000_8000);
		rdchk("status", `WDT_STAT_ADDR, 32'h0000_0000);
		rdchk("mask", `WDT_MASK_ADDR, 32'h0000_0003);
		rdchk("unmapped", 32'h5300_0014, 32'h0000_0000);
		chk("irq", wdog_irq, 32'h0000_0000);
		chk("rst_out", wdog_reset_out, 32'h0000_0000);
		$display("test reset values done");
		wr(`WDT_CTRL_ADDR, 16'hFFFF);
		rdchk("ctrl_rsvd", `WDT_CTRL_ADDR, 32'h0000_FF3D);
		wr(`WDT_CTRL_ADDR, ctl(8'h00, 2'b00, 1'b0, 1'b0, 1'b0));
		wr(`WDT_STAT_ADDR, 16'hFFFF);
		rdchk("status_ro", `WDT_STAT_ADDR, 32'h0000_0000);
		wr(`WDT_MASK_ADDR, 16'hFFFF);
		rdchk("mask_rsvd", `WDT_MASK_ADDR, 32'h0000_0003);
		n = 16'($urandom_range(16'hFFFF, 16'h0100));
		wr(`WDT_COUNT_ADDR, n);
		wr(`WDT_RELOAD_ADDR, ~n);
		rdchk("reload_rw", `WDT_RELOAD_ADDR, {16'h0000, ~n});
		repeat (100) @(posedge sys_clk);
		rdchk("count_held", `WDT_COUNT_ADDR, {16'h0000, n});
		wr(`WDT_CTRL_ADDR, ctl(8'h00, 2'b00, 1'b1, 1'b0, 1'b0));
		rdchk("count_no_load", `WDT_COUNT_ADDR, {16'h0000, n});
		$display("test enable and hold done");
		for (int d = 0; d < 4; d++)
		begin
			p = 8'($urandom_range(3));
			n = 16'($urandom_range(16'hFFFF, 16'h0100));
			arm(ctl(p, d[1:0], 1'b1, 1'b0, 1'b0), n);
			t = per(p, d[1:0]);
			// read lands mid-way between the second and third tick
			repeat (2 * t + t / 2 - 3) @(posedge sys_clk);
			rdchk("tick_count", `WDT_COUNT_ADDR, {16'h0000, n - 16'd2});
		end
		$display("test divider sweep done");
		r = 16'($urandom_range(16'h00FF, 16'h0010));
		wr(`WDT_RELOAD_ADDR, r);
		arm(ctl(8'h00, 2'b00, 1'b1, 1'b1, 1'b0), 16'h0002);
		repeat (38) @(posedge sys_clk);
		#1;
		chk("irq_timeout", wdog_irq, 32'h0000_0001);
		chk("rst_inhibit", wdog_reset_out, 32'h0000_0000);
		rdchk("count_reload", `WDT_COUNT_ADDR, {16'h0000, r});
		rdchk("status_set", `WDT_STAT_ADDR, 32'h0000_0001);
		rdchk("status_clr", `WDT_STAT_ADDR, 32'h0000_0000);
		chk("irq_clr", wdog_irq, 32'h0000_0000);
		wr(`WDT_MASK_ADDR, 16'h0000);
		arm(ctl(8'h00, 2'b00, 1'b1, 1'b1, 1'b0), 16'h0002);
		repeat (40) @(posedge sys_clk);
		#1;
		chk("irq_masked", wdog_irq, 32'h0000_0000);
		rdchk("status_masked", `WDT_STAT_ADDR, 32'h0000_0001);
		wr(`WDT_MASK_ADDR, 16'h0003);
		$display("test interval interrupt done");
		arm(ctl(8'h00, 2'b00, 1'b1, 1'b0, 1'b1), 16'h0001);
		w = 0;
		while (wdog_reset_out !== 1'b1 && w < 200)
		begin
			@(posedge sys_clk);
			#1;
			w++;
		end
		chk("rst_seen", wdog_reset_out, 32'h0000_0001);
		w = 0;
		while (wdog_reset_out === 1'b1 && w < 300)
		begin
			@(posedge sys_clk);
			#1;
			w++;
		end
		chk("rst_len", 32'(w), 32'd128);
		rdchk("status_rst", `WDT_STAT_ADDR, 32'h0000_0002);
		$display("test watchdog reset done");
		@(posedge sys_clk);
		core_debug_acknowledge <= 1'b1;
		arm(ctl(8'h00, 2'b00, 1'b1, 1'b1, 1'b1), 16'h0001);
		w = 0;
		repeat (40)
		begin
			@(posedge sys_clk);
			#1;
			if (wdog_reset_out !== 1'b0)
				w++;
		end
		chk("dbg_rst", 32'(w), 32'd0);
		rdchk("dbg_status", `WDT_STAT_ADDR, 32'h0000_0001);
		@(posedge sys_clk);
		core_debug_acknowledge <= 1'b0;
		$display("test debug suppression done");
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		rdchk("ctrl_rerst", `WDT_CTRL_ADDR, 32'h0000_8021);
		rdchk("count_rerst", `WDT_COUNT_ADDR, 32'h0000_8000);
		rdchk("status_rerst", `WDT_STAT_ADDR, 32'h0000_0000);
		chk("irq_rerst", wdog_irq, 32'h0000_0000);
		chk("rst_out_rerst", wdog_reset_out, 32'h0000_0000);
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
